// [design/sfl_flash_link.sv]
// Serial flash link: pin sampling, command capture, status output and busy timing.
//
// Overview of operation
// - Data is captured on rising serial clock edges and launched on falling edges.
// - Each opcode bit launched on a clock fall is captured on the next rise.
// - Mode 0 and mode 3 work up to 66 MHz, output valid in clock low; here the serial clock is sampled at 50 MHz, so it must run far slower.
// - General fast timing holds up to 66 MHz without low-phase output constraint; here output always launches on the clock fall, far below 66 MHz.
// - Ready/busy goes low within 100 ns of chip select rising on a timed command.
// - Deep power-down is entered within 3 us after its command ends.
// - Resume returns the device to standby within 35 us.
// - Page to buffer transfer ends busy within 300 us.
// - Page to buffer compare ends busy within 300 us.
// - Erase and program takes typically 17 ms, at most 40 ms.
// - Program without erase takes typically 3 ms, at most 6 ms.
// - Page erase takes typically 15 ms, at most 35 ms.
// - Eight-page block erase takes typically 45 ms, at most 100 ms.
// - Sector erase takes typically 1.6 s, at most 5 s.
// - Write protection follows the protect pin within 1 us both ways.
// - Each chip select fall picks mode 0 or 3 from the idle clock level.
// - After reset: mode 3, output off, and a chip select held low at release is taken as a new fall.
`timescale 1ns/1ns
`default_nettype none
module sfl_flash_link #(
    parameter int P_XFR_CYC  = sfl_pkg::CYC_XFR,
    parameter int P_COMP_CYC = sfl_pkg::CYC_COMP,
    parameter int P_EP_CYC   = sfl_pkg::CYC_EP,
    parameter int P_P_CYC    = sfl_pkg::CYC_P,
    parameter int P_PE_CYC   = sfl_pkg::CYC_PE,
    parameter int P_BE_CYC   = sfl_pkg::CYC_BE,
    parameter int P_SE_CYC   = sfl_pkg::CYC_SE,
    parameter int P_EDPD_CYC = sfl_pkg::CYC_EDPD,
    parameter int P_RDPD_CYC = sfl_pkg::CYC_RDPD
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic wp_n,
    input  wire logic reset_n,
    output var  logic so,
    output var  logic so_oe,
    output var  logic rdy_busy,
    output var  logic wp_active,
    output var  logic deep_pd,
    output var  logic mode3
);
    // =====================================================================
    // Pin sampling and edge detection
    // =====================================================================
    sfl_pkg::sfl_pins_s pins_raw;
    sfl_pkg::sfl_pins_s pins;
    logic               sck_q;
    logic               cs_q;
    logic               dev_rst;
    logic               sck_rise;
    logic               sck_fall;
    logic               cs_fall;
    logic               cs_rise;

    assign pins_raw = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n, rst_n: reset_n};

    sfl_sync #(
        .W       ($bits(sfl_pkg::sfl_pins_s)),
        .RST_VAL (sfl_pkg::PINS_IDLE)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .d    (pins_raw),
        .q    (pins)
    );

    // The reset pin acts like the system reset once synchronised.
    assign dev_rst = rst | ~pins.rst_n;

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            sck_q <= 1'b1;
            cs_q  <= 1'b1;
        end else if (ce) begin
            sck_q <= pins.sck;
            cs_q  <= pins.cs_n;
        end
    end

    assign sck_rise = ce & pins.sck & ~sck_q;
    assign sck_fall = ce & ~pins.sck & sck_q;
    assign cs_fall  = ce & cs_q & ~pins.cs_n;
    assign cs_rise  = ce & ~cs_q & pins.cs_n;

    // =====================================================================
    // Selection, mode pick and command capture
    // =====================================================================
    logic       sel;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic       op_done;

    assign op_done = (bit_cnt == sfl_pkg::BYTE_BITS);

    // A chip select already low at reset release counts as a fall and selects the device.
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            sel   <= 1'b0;
            mode3 <= 1'b1;
        end else if (cs_fall) begin
            sel   <= 1'b1;
            mode3 <= pins.sck;
        end else if (cs_rise) begin
            sel   <= 1'b0;
        end
    end

    // Only the opcode byte is kept; later bits are ignored once the count reaches eight.
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            bit_cnt <= '0;
            shreg   <= '0;
        end else if (cs_fall) begin
            bit_cnt <= '0;
        end else if (sel && sck_rise && !op_done) begin
            shreg   <= {shreg[6:0], pins.si};
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // =====================================================================
    // Status byte output
    // =====================================================================
    sfl_pkg::sfl_state_e state;
    logic [7:0]          status;
    logic [7:0]          out_sh;
    logic                talk;

    always_comb begin
        status                    = '0;
        status[sfl_pkg::ST_RDY]   = rdy_busy;
        status[sfl_pkg::ST_DPD]   = deep_pd;
        status[sfl_pkg::ST_WP]    = wp_active;
        status[sfl_pkg::ST_MODE3] = mode3;
    end

    assign talk = sel && op_done && (shreg == sfl_pkg::OP_STATUS) && !deep_pd;

    // The status byte repeats for as long as the host keeps clocking.
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            so     <= 1'b0;
            so_oe  <= 1'b0;
            out_sh <= '0;
        end else if (cs_rise) begin
            so_oe  <= 1'b0;
        end else if (sel && sck_rise && bit_cnt == 4'h7) begin
            out_sh <= status;
        end else if (talk && sck_fall) begin
            so     <= out_sh[7];
            so_oe  <= 1'b1;
            out_sh <= {out_sh[6:0], out_sh[7]};
        end
    end

    // =====================================================================
    // Write protect
    // =====================================================================
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            wp_active <= 1'b0;
        end else if (ce) begin
            wp_active <= ~pins.wp_n;
        end
    end

    // =====================================================================
    // Operation sequencing
    // =====================================================================
    logic              cmd_end;
    logic              is_timed;
    logic              is_write;
    sfl_pkg::sfl_cnt_t next_load_val;
    logic              next_load;
    logic              tmr_done;
    logic              tmr_running;
    logic [7:0]        busy_op;

    assign cmd_end = cs_rise && sel && op_done;

    always_comb begin
        is_timed      = 1'b1;
        is_write      = 1'b1;
        next_load_val = '0;
        unique case (shreg)
            sfl_pkg::OP_XFR: begin
                is_write      = 1'b0;
                next_load_val = sfl_pkg::sfl_cnt_t'(P_XFR_CYC);
            end
            sfl_pkg::OP_COMP: begin
                is_write      = 1'b0;
                next_load_val = sfl_pkg::sfl_cnt_t'(P_COMP_CYC);
            end
            sfl_pkg::OP_EP:     next_load_val = sfl_pkg::sfl_cnt_t'(P_EP_CYC);
            sfl_pkg::OP_PROG:   next_load_val = sfl_pkg::sfl_cnt_t'(P_P_CYC);
            sfl_pkg::OP_PERASE: next_load_val = sfl_pkg::sfl_cnt_t'(P_PE_CYC);
            sfl_pkg::OP_BERASE: next_load_val = sfl_pkg::sfl_cnt_t'(P_BE_CYC);
            sfl_pkg::OP_SERASE: next_load_val = sfl_pkg::sfl_cnt_t'(P_SE_CYC);
            sfl_pkg::OP_DPD: begin
                is_timed      = 1'b0;
                is_write      = 1'b0;
                next_load_val = sfl_pkg::sfl_cnt_t'(P_EDPD_CYC);
            end
            sfl_pkg::OP_RESUME: begin
                is_timed      = 1'b0;
                is_write      = 1'b0;
                next_load_val = sfl_pkg::sfl_cnt_t'(P_RDPD_CYC);
            end
            default: begin
                is_timed = 1'b0;
                is_write = 1'b0;
            end
        endcase
    end

    // Program and erase commands are dropped while protection holds.
    always_comb begin
        next_load = 1'b0;
        if (cmd_end) begin
            if (state == sfl_pkg::ST_IDLE) begin
                next_load = (is_timed && !(is_write && wp_active))
                            || shreg == sfl_pkg::OP_DPD;
            end else if (state == sfl_pkg::ST_PD) begin
                next_load = (shreg == sfl_pkg::OP_RESUME);
            end
        end
    end

    sfl_timer #(
        .W (sfl_pkg::TMR_W)
    ) u_timer (
        .mclk     (mclk),
        .rst      (dev_rst),
        .ce       (ce),
        .load     (next_load),
        .load_val (next_load_val),
        .running  (tmr_running),
        .done     (tmr_done)
    );

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            state    <= sfl_pkg::ST_IDLE;
            rdy_busy <= 1'b1;
            deep_pd  <= 1'b0;
            busy_op  <= '0;
        end else if (ce) begin
            unique case (state)
                sfl_pkg::ST_IDLE: begin
                    if (next_load && is_timed) begin
                        state    <= sfl_pkg::ST_BUSY;
                        rdy_busy <= 1'b0;
                        busy_op  <= shreg;
                    end else if (next_load) begin
                        state    <= sfl_pkg::ST_PD_ENTRY;
                    end
                end
                sfl_pkg::ST_BUSY: begin
                    if (tmr_done) begin
                        state    <= sfl_pkg::ST_IDLE;
                        rdy_busy <= 1'b1;
                    end
                end
                sfl_pkg::ST_PD_ENTRY: begin
                    if (tmr_done) begin
                        state   <= sfl_pkg::ST_PD;
                        deep_pd <= 1'b1;
                    end
                end
                sfl_pkg::ST_PD: begin
                    if (next_load) begin
                        state <= sfl_pkg::ST_PD_EXIT;
                    end
                end
                sfl_pkg::ST_PD_EXIT: begin
                    if (tmr_done) begin
                        state   <= sfl_pkg::ST_IDLE;
                        deep_pd <= 1'b0;
                    end
                end
                default: begin
                    state    <= sfl_pkg::ST_IDLE;
                    rdy_busy <= 1'b1;
                    deep_pd  <= 1'b0;
                end
            endcase
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    sfl_pkg::sfl_cnt_t busy_cnt;
    sfl_pkg::sfl_cnt_t exit_cnt;

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            busy_cnt <= '0;
            exit_cnt <= '0;
        end else if (ce) begin
            busy_cnt <= rdy_busy ? '0 : busy_cnt + 1'b1;
            exit_cnt <= (state == sfl_pkg::ST_PD_EXIT) ? exit_cnt + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (dev_rst || !ce);

    capture_rise_a: assert property (sel && sck_rise && !op_done
        |=> shreg[0] == $past(pins.si)) else $error("bit not captured on rise");
    launch_fall_a: assert property ($changed(so) |-> $past(sck_fall))
        else $error("output changed off a falling edge");
    busy_low_a: assert property (cmd_end && state == sfl_pkg::ST_IDLE && is_timed
        && !(is_write && wp_active) |=> !rdy_busy) else $error("busy not raised");
    pd_entry_a: assert property ($rose(state == sfl_pkg::ST_PD_ENTRY)
        |-> ##[1:152] deep_pd) else $error("power-down entry late");
    pd_exit_a: assert property (exit_cnt <= sfl_pkg::sfl_cnt_t'(P_RDPD_CYC + 2))
        else $error("power-down exit late");
    xfr_time_a: assert property (busy_op == sfl_pkg::OP_XFR
        |-> busy_cnt <= sfl_pkg::sfl_cnt_t'(P_XFR_CYC + 2)) else $error("transfer late");
    comp_time_a: assert property (busy_op == sfl_pkg::OP_COMP
        |-> busy_cnt <= sfl_pkg::sfl_cnt_t'(P_COMP_CYC + 2)) else $error("compare late");
    ep_time_a: assert property (busy_op == sfl_pkg::OP_EP
        |-> busy_cnt <= sfl_pkg::sfl_cnt_t'(P_EP_CYC + 2)) else $error("erase-program late");
    prog_time_a: assert property (busy_op == sfl_pkg::OP_PROG
        |-> busy_cnt <= sfl_pkg::sfl_cnt_t'(P_P_CYC + 2)) else $error("program late");
    perase_time_a: assert property (busy_op == sfl_pkg::OP_PERASE
        |-> busy_cnt <= sfl_pkg::sfl_cnt_t'(P_PE_CYC + 2)) else $error("page erase late");
    berase_time_a: assert property (busy_op == sfl_pkg::OP_BERASE
        |-> busy_cnt <= sfl_pkg::sfl_cnt_t'(P_BE_CYC + 2)) else $error("block erase late");
    serase_time_a: assert property (busy_op == sfl_pkg::OP_SERASE
        |-> busy_cnt <= sfl_pkg::sfl_cnt_t'(P_SE_CYC + 2)) else $error("sector erase late");
    wp_follow_a: assert property ($changed(wp_n) |-> ##3 wp_active == !$past(wp_n, 3))
        else $error("protect pin not followed");
    mode_pick_a: assert property (cs_fall |=> mode3 == $past(pins.sck))
        else $error("mode not sampled");
    reset_state_a: assert property ($fell(dev_rst) |-> mode3 && !so_oe && !sel)
        else $error("reset state wrong");
    ready_end_a: assert property ($fell(state == sfl_pkg::ST_BUSY) |-> rdy_busy
        && $past(!rdy_busy)) else $error("ready not restored");

    status_read_c: cover property (talk && sck_fall);
    busy_op_c:     cover property ($rose(rdy_busy));
    pd_cycle_c:    cover property ($fell(deep_pd));
endmodule
`default_nettype wire

// [design/sfl_pkg.sv]
// Shared constants, timings and carrier types of the serial flash link block.
package sfl_pkg;

    // =====================================================================
    // Clock and timing
    // =====================================================================
    localparam int  CLK_MHZ     = 50;
    localparam int  TMR_W       = 28;
    localparam int  T_CSB_NS    = 100;
    localparam int  T_WP_NS     = 1000;
    localparam int  T_EDPD_US   = 3;
    localparam int  T_RDPD_US   = 35;
    localparam int  T_XFR_US    = 300;
    localparam int  T_COMP_US   = 300;
    localparam int  T_EP_MS     = 17;
    localparam int  T_P_MS      = 3;
    localparam int  T_PE_MS     = 15;
    localparam int  T_BE_MS     = 45;
    localparam real T_SE_S      = 1.6;
    // Times convert to whole cycles; program and erase use the typical times.
    localparam int  CYC_CSB     = T_CSB_NS * CLK_MHZ / 1000;
    localparam int  CYC_WP      = T_WP_NS * CLK_MHZ / 1000;
    localparam int  CYC_EDPD    = T_EDPD_US * CLK_MHZ;
    localparam int  CYC_RDPD    = T_RDPD_US * CLK_MHZ;
    localparam int  CYC_XFR     = T_XFR_US * CLK_MHZ;
    localparam int  CYC_COMP    = T_COMP_US * CLK_MHZ;
    localparam int  CYC_EP      = T_EP_MS * CLK_MHZ * 1000;
    localparam int  CYC_P       = T_P_MS * CLK_MHZ * 1000;
    localparam int  CYC_PE      = T_PE_MS * CLK_MHZ * 1000;
    localparam int  CYC_BE      = T_BE_MS * CLK_MHZ * 1000;
    localparam int  CYC_SE      = int'(T_SE_S * 1000.0) * CLK_MHZ * 1000;

    typedef logic [TMR_W-1:0] sfl_cnt_t;

    // =====================================================================
    // Command codes and status byte layout
    // =====================================================================
    localparam logic [7:0] OP_XFR    = 8'h01;
    localparam logic [7:0] OP_COMP   = 8'h02;
    localparam logic [7:0] OP_EP     = 8'h03;
    localparam logic [7:0] OP_PROG   = 8'h04;
    localparam logic [7:0] OP_PERASE = 8'h05;
    localparam logic [7:0] OP_BERASE = 8'h06;
    localparam logic [7:0] OP_SERASE = 8'h07;
    localparam logic [7:0] OP_DPD    = 8'h08;
    localparam logic [7:0] OP_RESUME = 8'h09;
    localparam logic [7:0] OP_STATUS = 8'h0a;
    localparam int         ST_RDY    = 7;
    localparam int         ST_DPD    = 6;
    localparam int         ST_WP     = 5;
    localparam int         ST_MODE3  = 4;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // =====================================================================
    // Types
    // =====================================================================
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        logic rst_n;
    } sfl_pins_s;

    localparam sfl_pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b1, si: 1'b0,
                                        wp_n: 1'b1, rst_n: 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_BUSY     = 3'h1,
        ST_PD_ENTRY = 3'h2,
        ST_PD       = 3'h3,
        ST_PD_EXIT  = 3'h4
    } sfl_state_e;

endpackage

// [design/sfl_sync.sv]
// Two-flip-flop synchroniser for the pin inputs of the serial flash link.
`timescale 1ns/1ns
`default_nettype none
module sfl_sync #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           mclk,
    input  wire logic           rst,
    input  wire logic           ce,
    input  wire logic [W-1:0]   d,
    output var  logic [W-1:0]   q
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// [design/sfl_timer.sv]
// Loadable down-counter that times the self-timed and power-mode operations.
`timescale 1ns/1ns
`default_nettype none
module sfl_timer #(
    parameter int               W = 28
) (
    input  wire logic           mclk,
    input  wire logic           rst,
    input  wire logic           ce,
    input  wire logic           load,
    input  wire logic [W-1:0]   load_val,
    output var  logic           running,
    output var  logic           done
);
    logic [W-1:0] cnt;

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt     <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (load) begin
                cnt     <= load_val;
                running <= 1'b1;
            end else if (running) begin
                if (cnt <= W'(1)) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    cnt <= cnt - W'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verif/sfl_host.sv]
// Host controller model that drives the serial flash link pins.
`timescale 1ns/1ns
`default_nettype none
module sfl_host (
    input  wire logic mclk,
    input  wire logic so,
    input  wire logic so_oe,
    output var  logic cs_n,
    output var  logic sck,
    output var  logic si
);
    logic so_last = 1'b0;
    logic so_w;

    // A released output line shows the inverse of its last driven level.
    always @(posedge mclk) begin
        if (so_oe) begin
            so_last <= so;
        end
    end
    assign so_w = so_oe ? so : !so_last;

    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        si = 1'b0;
    end

    // Half a serial period of 80 ns keeps the link far below both clock ceilings.
    task automatic half();
        repeat (4) @(posedge mclk);
    endtask

    // =====================================================================
    // One framed command, with an optional status byte read after it
    // =====================================================================
    task automatic cmd(input logic [7:0] op, input logic idle, input logic rd,
                       output logic [7:0] st, output logic oe_seen);
        st = 8'h00;
        oe_seen = 1'b0;
        @(posedge mclk);
        sck <= idle;
        half();
        cs_n <= 1'b0;
        half();
        for (int i = 0; i < 17; i++) begin
            if (i > 8) begin
                st = {st[6:0], so_w};
                oe_seen = oe_seen | so_oe;
            end
            if (i == 16 || (i == 8 && !rd)) begin
                break;
            end
            sck <= 1'b0;
            si <= (i < 8) ? op[7-i] : !si;
            half();
            sck <= 1'b1;
            half();
        end
        sck <= idle;
        half();
        cs_n <= 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

// [verif/tb_sfl_flash_link.sv]
// Self-checking testbench of the serial flash link block.
`timescale 1ns/1ns
`default_nettype none
module tb_sfl_flash_link;
    localparam int EDPD = sfl_pkg::CYC_EDPD;
    localparam int RDPD = sfl_pkg::CYC_RDPD;
    localparam logic [7:0] OPS [7] = '{sfl_pkg::OP_XFR, sfl_pkg::OP_COMP, sfl_pkg::OP_EP,
        sfl_pkg::OP_PROG, sfl_pkg::OP_PERASE, sfl_pkg::OP_BERASE, sfl_pkg::OP_SERASE};
    localparam int CYC [7] = '{sfl_pkg::CYC_XFR, sfl_pkg::CYC_COMP, 28, 32, 36, 40, 44};

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic reset_n = 1'b1;
    logic ce = 1'b1;
    logic cs_n, sck, si, so, so_oe, rdy_busy, wp_active, deep_pd, mode3;
    logic cs_d = 1'b1;
    logic rb_d = 1'b1;
    logic [7:0] st;
    logic oe, wp, idle;
    int since_cs = 0;
    int num_errors = 0;
    int compares = 0;
    int exp_q[$];

    `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
        $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

    always #10 mclk = !mclk;

    sfl_host host (.mclk(mclk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));

    // Only the program and erase operations are shortened; the rest run at full length.
    sfl_flash_link #(.P_EP_CYC(28), .P_P_CYC(32), .P_PE_CYC(36), .P_BE_CYC(40),
        .P_SE_CYC(44)) dut (
        .mclk(mclk), .rst(rst), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si),
        .wp_n(wp_n), .reset_n(reset_n), .so(so), .so_oe(so_oe), .rdy_busy(rdy_busy),
        .wp_active(wp_active), .deep_pd(deep_pd), .mode3(mode3));

    task automatic conclude();
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // =====================================================================
    // Watcher: times busy against the chip select rise and the noted length
    // =====================================================================
    always @(posedge mclk) begin
        cs_d <= cs_n;
        rb_d <= rdy_busy;
        since_cs <= (cs_n && !cs_d) ? 1 : since_cs + 1;
        if (rb_d && !rdy_busy) `CHK("busy_fall", 1'b1, since_cs <= 4)
        if (!rb_d && rdy_busy && exp_q.size() > 0) begin
            // Two synchroniser stages and the edge detect add a few cycles to each span.
            `CHK("busy_span", 1'b1, since_cs >= exp_q[0] + 2 && since_cs <= exp_q[0] + 6)
            void'(exp_q.pop_front());
        end
    end

    initial begin
        repeat (50000) @(posedge mclk);
        num_errors++;
        conclude();
    end

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        void'($urandom(32'h6167));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK("reset_outs", 4'b0011, {so_oe, deep_pd, rdy_busy, mode3})
        // A low clock enable must hold the protect flag although the pin moves.
        ce <= 1'b0;
        @(posedge mclk);
        wp_n <= 1'b0;
        repeat (8) @(posedge mclk);
        `CHK("ce_freeze", 1'b0, wp_active)
        ce <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK("ce_resume", 1'b1, wp_active)
        wp_n <= 1'b1;
        repeat (6) @(posedge mclk);
        for (int i = 0; i < 7; i++) begin
            exp_q.push_back(CYC[i]);
            host.cmd(OPS[i], i[0], 1'b0, st, oe);
            repeat (CYC[i] + 12) @(posedge mclk);
        end
        `CHK("spans_left", 0, exp_q.size())
        for (int i = 0; i < 4; i++) begin
            wp = 1'($urandom);
            idle = 1'($urandom);
            wp_n <= !wp;
            repeat (50) @(posedge mclk);
            `CHK("wp_active", wp, wp_active)
            host.cmd(sfl_pkg::OP_STATUS, idle, 1'b1, st, oe);
            `CHK("status", {1'b1, 1'b0, wp, idle, 4'h0}, st)
            if (!wp) exp_q.push_back(32);
            host.cmd(sfl_pkg::OP_PROG, idle, 1'b0, st, oe);
            repeat (6) @(posedge mclk);
            `CHK("prog_gate", wp, rdy_busy)
            repeat (44) @(posedge mclk);
        end
        wp_n <= 1'b1;
        host.cmd(sfl_pkg::OP_DPD, 1'b1, 1'b0, st, oe);
        repeat (EDPD + 4) @(posedge mclk);
        `CHK("pd_entry", 2'b11, {deep_pd, rdy_busy})
        host.cmd(sfl_pkg::OP_STATUS, 1'b1, 1'b1, st, oe);
        `CHK("pd_quiet", 1'b0, oe)
        host.cmd(sfl_pkg::OP_RESUME, 1'b1, 1'b0, st, oe);
        `CHK("pd_hold", 1'b1, deep_pd)
        repeat (RDPD + 4) @(posedge mclk);
        `CHK("pd_exit", 1'b0, deep_pd)
        host.cmd(sfl_pkg::OP_STATUS, 1'b0, 1'b1, st, oe);
        `CHK("mode0", 1'b0, mode3)
        // Chip select is already high here, so the reset pin may be pulsed.
        reset_n <= 1'b0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK("reset_pin", 2'b10, {mode3, so_oe})
        conclude();
    end
endmodule
`default_nettype wire
